// *** src/pcpio_target.sv ***
// programmed-io completer behind the endpoint request and completion streams
//
// How it works
// - four separate 2 KB regions, each tied to a distinct bar
// - every region is its own 2 KB dual-port memory
// - match code 001b selects the 64-bit memory region
// - match code 110b selects the expansion rom region
// - match code 010b selects the 32-bit memory region
// - match code 000b with an io request selects the io region
// - only one space per type is served; other codes get no completion
// - only low address bits decode, so larger apertures wrap onto 2 KB
// - io region is off by default and enabled by parameter
// - requests longer than one dword are taken in full and dropped
// - writes store the payload dword at the low address bits
// - io writes are answered with a completion without data
// - ready stays low while a memory write is in progress
// - reads return a completion with the addressed dword
// - ready stays low until the read completion has been sent
// - ready falls after a full request, returns once it is dropped, written to memory or its completion is sent
// - next write is accepted only once write busy has cleared
// - stream width may be 64, 128 or 256 bits
// - each valid read completion carries exactly one dword of payload
`timescale 1ns/100ps
module pcpio_target
  import pcpio_pkg::*;
#(
  parameter int DATA_WIDTH = PCPIO_DEF_WIDTH,
  parameter bit IO_ENABLE  = 1'b0
)(
  input  wire logic                    core_clk_i,
  input  wire logic                    resetn_i,
  input  wire logic [DATA_WIDTH-1:0]   cq_tdata_i,
  input  wire logic                    cq_tvalid_i,
  input  wire logic                    cq_tlast_i,
  output logic                         completer_request_ready_o,
  output logic      [DATA_WIDTH-1:0]   cc_tdata_o,
  output logic      [DATA_WIDTH/32-1:0] cc_tkeep_o,
  output logic                         cc_tvalid_o,
  output logic                         cc_tlast_o,
  input  wire logic                    cc_tready_i,
  output logic                         write_busy_o,
  output logic                         cpl_sent_o
);

  // ==========================================================
  // width-dependent sizes
  localparam int DPB       = DATA_WIDTH / 32;
  localparam int ACC_BEATS = PCPIO_ACC_BITS / DATA_WIDTH;
  localparam int CPL_BEATS = (DATA_WIDTH == 64) ? 2 : 1;

  pcpio_state_t                   state;
  pcpio_state_t                   next_state;
  logic [2:0]                     beat_cnt;
  logic [PCPIO_ACC_BITS-1:0]      acc;
  logic [PCPIO_CPL_BITS-1:0]      cpl_word;
  logic [2:0]                     cpl_dwords;
  logic [1:0]                     cpl_beat;
  logic                           cpl_last_beat;
  logic [1:0]                     sel;
  logic [PCPIO_RAM_AW-1:0]        ram_addr;
  logic [31:0]                    ram_wdata;
  logic                           is_io_write;

  // decoded request fields
  logic [3:0]                     req_type;
  logic [2:0]                     req_bar;
  logic [PCPIO_DWCNT_W-1:0]       req_dwcnt;
  logic                           req_hit;
  logic [1:0]                     req_sel;
  logic                           req_read;
  logic                           req_mem;
  logic                           req_io;

  logic [PCPIO_REGIONS-1:0]       rgn_wr_en;
  logic [PCPIO_REGIONS-1:0]       rgn_rd_en;
  logic [31:0]                    rgn_rd_data [PCPIO_REGIONS];

  // ==========================================================
  // request field extraction and bar steering
  assign req_type  = acc[PCPIO_TYPE_LO +: 4];
  assign req_bar   = acc[PCPIO_BAR_LO +: 3];
  assign req_dwcnt = acc[PCPIO_DWCNT_LO +: PCPIO_DWCNT_W];
  assign req_mem   = (req_type == PCPIO_REQ_MRD) ||
                     (req_type == PCPIO_REQ_MWR);
  assign req_io    = (req_type == PCPIO_REQ_IORD) ||
                     (req_type == PCPIO_REQ_IOWR);
  assign req_read  = (req_type == PCPIO_REQ_MRD) ||
                     (req_type == PCPIO_REQ_IORD);

  always_comb begin
    req_hit = 1'b0;
    req_sel = PCPIO_RGN_IO;
    case (req_bar)
      PCPIO_BAR_IO: begin
        req_hit = IO_ENABLE && req_io;
        req_sel = PCPIO_RGN_IO;
      end
      PCPIO_BAR_MEM64: begin
        req_hit = req_mem;
        req_sel = PCPIO_RGN_MEM64;
      end
      PCPIO_BAR_MEM32: begin
        req_hit = req_mem;
        req_sel = PCPIO_RGN_MEM32;
      end
      PCPIO_BAR_EROM: begin
        req_hit = req_mem;
        req_sel = PCPIO_RGN_EROM;
      end
      default: begin
        req_hit = 1'b0;
        req_sel = PCPIO_RGN_IO;
      end
    endcase
  end

  // ==========================================================
  // main sequence
  assign cpl_last_beat = (32'(cpl_beat) == CPL_BEATS - 1);

  always_comb begin
    next_state = state;
    case (state)
      PCPIO_S_RECV: begin
        if (cq_tvalid_i && cq_tlast_i) begin
          next_state = PCPIO_S_DECODE;
        end
      end
      PCPIO_S_DECODE: begin
        if (!req_hit || req_dwcnt != PCPIO_DWCNT_W'(1)) begin
          next_state = PCPIO_S_RECV;
        end else if (req_read) begin
          next_state = PCPIO_S_READ;
        end else begin
          next_state = PCPIO_S_WRITE;
        end
      end
      PCPIO_S_WRITE: begin
        if (is_io_write) begin
          next_state = PCPIO_S_SEND;
        end else begin
          next_state = PCPIO_S_RECV;
        end
      end
      PCPIO_S_READ: begin
        next_state = PCPIO_S_RWAIT;
      end
      PCPIO_S_RWAIT: begin
        next_state = PCPIO_S_SEND;
      end
      PCPIO_S_SEND: begin
        if (cc_tready_i && cpl_last_beat) begin
          next_state = PCPIO_S_RECV;
        end
      end
      default: begin
        next_state = PCPIO_S_RECV;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= PCPIO_S_RECV;
    end else begin
      state <= next_state;
    end
  end

  // ready only while collecting a request
  assign completer_request_ready_o = (state == PCPIO_S_RECV);
  assign write_busy_o = (state == PCPIO_S_WRITE);

  // ==========================================================
  // request beat collection
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      beat_cnt <= 3'h0;
    end else if (state == PCPIO_S_RECV && cq_tvalid_i) begin
      if (cq_tlast_i) begin
        beat_cnt <= 3'h0;
      end else if (beat_cnt != 3'h7) begin
        beat_cnt <= beat_cnt + 3'h1;
      end
    end
  end

  // whole request is taken even when too long to keep
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc <= '0;
    end else if (state == PCPIO_S_RECV && cq_tvalid_i &&
                 32'(beat_cnt) < ACC_BEATS) begin
      acc[32'(beat_cnt) * DATA_WIDTH +: DATA_WIDTH] <= cq_tdata_i;
    end
  end

  // ==========================================================
  // latched access target
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel         <= PCPIO_RGN_IO;
      ram_addr    <= '0;
      ram_wdata   <= 32'h0000_0000;
      is_io_write <= 1'b0;
    end else if (state == PCPIO_S_DECODE) begin
      sel         <= req_sel;
      ram_addr    <= acc[PCPIO_ADDR_LO +: PCPIO_RAM_AW];
      ram_wdata   <= acc[PCPIO_PAYLOAD_LO +: 32];
      is_io_write <= (req_type == PCPIO_REQ_IOWR);
    end
  end

  always_comb begin
    for (int i = 0; i < PCPIO_REGIONS; i++) begin
      rgn_wr_en[i] = (state == PCPIO_S_WRITE) && (sel == 2'(i));
      rgn_rd_en[i] = (state == PCPIO_S_READ) && (sel == 2'(i));
    end
  end

  // ==========================================================
  // region memories
  for (genvar g = 0; g < PCPIO_REGIONS; g++) begin : g_rgn
    pcpio_region_ram u_ram (
      .core_clk_i (core_clk_i),
      .wr_en_i    (rgn_wr_en[g]),
      .wr_addr_i  (ram_addr),
      .wr_data_i  (ram_wdata),
      .rd_en_i    (rgn_rd_en[g]),
      .rd_addr_i  (ram_addr),
      .rd_data_o  (rgn_rd_data[g])
    );
  end

  // ==========================================================
  // completion build
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpl_word   <= '0;
      cpl_dwords <= PCPIO_CPL_DW_NODATA;
    end else if (state == PCPIO_S_DECODE) begin
      cpl_word <= '0;
      cpl_word[PCPIO_C_LADDR_LO +: 7] <=
        req_mem ? acc[6:0] : 7'h00;
      cpl_word[PCPIO_C_BCNT_LO +: 13] <= PCPIO_CPL_BYTES;
      cpl_word[PCPIO_C_DWCNT_LO +: PCPIO_DWCNT_W] <=
        req_read ? PCPIO_DWCNT_W'(1) : PCPIO_DWCNT_W'(0);
      cpl_word[PCPIO_C_STAT_LO +: 3] <= PCPIO_CPL_SUCCESS;
      cpl_word[PCPIO_C_REQID_LO +: 16] <= acc[PCPIO_REQID_LO +: 16];
      cpl_word[PCPIO_C_TAG_LO +: 8] <= acc[PCPIO_TAG_LO +: 8];
      cpl_word[PCPIO_C_TC_LO +: 3] <= acc[PCPIO_TC_LO +: 3];
      cpl_word[PCPIO_C_ATTR_LO +: 3] <= acc[PCPIO_ATTR_LO +: 3];
      cpl_dwords <= req_read ? PCPIO_CPL_DW_DATA : PCPIO_CPL_DW_NODATA;
    end else if (state == PCPIO_S_RWAIT) begin
      cpl_word[PCPIO_C_DATA_LO +: 32] <= rgn_rd_data[sel];
    end
  end

  // ==========================================================
  // completion stream
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpl_beat <= 2'h0;
    end else if (state == PCPIO_S_SEND && cc_tready_i) begin
      cpl_beat <= cpl_last_beat ? 2'h0 : cpl_beat + 2'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpl_sent_o <= 1'b0;
    end else begin
      cpl_sent_o <= (state == PCPIO_S_SEND) && cc_tready_i &&
                    cpl_last_beat;
    end
  end

  assign cc_tvalid_o = (state == PCPIO_S_SEND);
  assign cc_tlast_o  = (state == PCPIO_S_SEND) && cpl_last_beat;
  assign cc_tdata_o  = cpl_word[32'(cpl_beat) * DATA_WIDTH +: DATA_WIDTH];

  always_comb begin
    for (int i = 0; i < DPB; i++) begin
      cc_tkeep_o[i] = (state == PCPIO_S_SEND) &&
                      (32'(cpl_beat) * DPB + i < 32'(cpl_dwords));
    end
  end

endmodule : pcpio_target

// *** include/pcpio_pkg.sv ***
// constants and types shared by the programmed-io completer
package pcpio_pkg;

  // ==========================================================
  // datapath and memory geometry
  localparam int          PCPIO_DEF_WIDTH   = 64;
  localparam int          PCPIO_ACC_BITS    = 256;
  localparam int          PCPIO_CPL_BITS    = 256;
  localparam int          PCPIO_REGIONS     = 4;
  localparam int          PCPIO_RAM_BYTES   = 2048;
  localparam int          PCPIO_RAM_WORDS   = PCPIO_RAM_BYTES / 4;
  localparam int          PCPIO_RAM_AW      = 9;

  // ==========================================================
  // request descriptor field positions
  localparam int          PCPIO_ADDR_LO     = 2;
  localparam int          PCPIO_DWCNT_LO    = 64;
  localparam int          PCPIO_DWCNT_W     = 11;
  localparam int          PCPIO_TYPE_LO     = 75;
  localparam int          PCPIO_REQID_LO    = 80;
  localparam int          PCPIO_TAG_LO      = 96;
  localparam int          PCPIO_BAR_LO      = 112;
  localparam int          PCPIO_TC_LO       = 121;
  localparam int          PCPIO_ATTR_LO     = 124;
  localparam int          PCPIO_PAYLOAD_LO  = 128;

  // ==========================================================
  // completion descriptor field positions
  localparam int          PCPIO_C_LADDR_LO  = 0;
  localparam int          PCPIO_C_BCNT_LO   = 16;
  localparam int          PCPIO_C_DWCNT_LO  = 32;
  localparam int          PCPIO_C_STAT_LO   = 43;
  localparam int          PCPIO_C_REQID_LO  = 48;
  localparam int          PCPIO_C_TAG_LO    = 64;
  localparam int          PCPIO_C_TC_LO     = 89;
  localparam int          PCPIO_C_ATTR_LO   = 92;
  localparam int          PCPIO_C_DATA_LO   = 96;
  localparam logic [2:0]  PCPIO_CPL_SUCCESS = 3'h0;
  localparam logic [12:0] PCPIO_CPL_BYTES   = 13'h0004;
  localparam logic [2:0]  PCPIO_CPL_DW_NODATA = 3'h3;
  localparam logic [2:0]  PCPIO_CPL_DW_DATA = 3'h4;

  // ==========================================================
  // request types and bar match codes
  localparam logic [3:0]  PCPIO_REQ_MRD     = 4'h0;
  localparam logic [3:0]  PCPIO_REQ_MWR     = 4'h1;
  localparam logic [3:0]  PCPIO_REQ_IORD    = 4'h2;
  localparam logic [3:0]  PCPIO_REQ_IOWR    = 4'h3;
  localparam logic [2:0]  PCPIO_BAR_IO      = 3'h0;
  localparam logic [2:0]  PCPIO_BAR_MEM64   = 3'h1;
  localparam logic [2:0]  PCPIO_BAR_MEM32   = 3'h2;
  localparam logic [2:0]  PCPIO_BAR_EROM    = 3'h6;

  // ==========================================================
  // region indices
  localparam logic [1:0]  PCPIO_RGN_IO      = 2'h0;
  localparam logic [1:0]  PCPIO_RGN_MEM32   = 2'h1;
  localparam logic [1:0]  PCPIO_RGN_MEM64   = 2'h2;
  localparam logic [1:0]  PCPIO_RGN_EROM    = 2'h3;

  typedef enum logic [2:0] {
    PCPIO_S_RECV   = 3'b000,
    PCPIO_S_DECODE = 3'b001,
    PCPIO_S_WRITE  = 3'b010,
    PCPIO_S_READ   = 3'b011,
    PCPIO_S_RWAIT  = 3'b100,
    PCPIO_S_SEND   = 3'b101
  } pcpio_state_t;

endpackage : pcpio_pkg

// *** src/pcpio_region_ram.sv ***
// one 2 KB dual-port region memory, write port and registered read port
`timescale 1ns/100ps
module pcpio_region_ram
  import pcpio_pkg::*;
(
  input  wire logic                    core_clk_i,
  input  wire logic                    wr_en_i,
  input  wire logic [PCPIO_RAM_AW-1:0] wr_addr_i,
  input  wire logic [31:0]             wr_data_i,
  input  wire logic                    rd_en_i,
  input  wire logic [PCPIO_RAM_AW-1:0] rd_addr_i,
  output logic      [31:0]             rd_data_o
);

  logic [31:0] mem [PCPIO_RAM_WORDS];

  // ==========================================================
  // write port
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge core_clk_i) begin
    if (rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule : pcpio_region_ram

// *** testbench/pcpio_core_model.sv ***
// endpoint core model: request source and completion sink
`timescale 1ns/100ps
module pcpio_core_model (
  input  wire logic         core_clk_i,
  input  wire logic         stall_i,
  input  wire logic         ready_i,
  output logic      [63:0]  cq_tdata_o,
  output logic              cq_tvalid_o,
  output logic              cq_tlast_o,
  input  wire logic [63:0]  cc_tdata_i,
  input  wire logic         cc_tvalid_i,
  input  wire logic         cc_tlast_i,
  output logic              cc_tready_o,
  output logic      [127:0] cpl_o,
  output int                cpl_cnt_o
);
  int beat;
  initial begin
    cq_tdata_o  = '0;
    cq_tvalid_o = 1'b0;
    cq_tlast_o  = 1'b0;
    cc_tready_o = 1'b1;
    cpl_o       = '0;
    cpl_cnt_o   = 0;
    beat        = 0;
  end
  // ==========================================================
  // request source, low beat first, held until ready
  task automatic send(input logic [191:0] req, input int nb);
    @(posedge core_clk_i);
    for (int i = 0; i < nb; i++) begin
      cq_tdata_o  <= req[i*64 +: 64];
      cq_tvalid_o <= 1'b1;
      cq_tlast_o  <= (i == nb - 1);
      @(posedge core_clk_i);
      while (ready_i !== 1'b1) @(posedge core_clk_i);
    end
    cq_tvalid_o <= 1'b0;
    cq_tlast_o  <= 1'b0;
    cq_tdata_o  <= ~cq_tdata_o;  // released lines show no stale beat
  endtask : send
  // ==========================================================
  // completion sink, stalls every other cycle when asked
  always @(posedge core_clk_i) begin
    cc_tready_o <= stall_i ? ~cc_tready_o : 1'b1;
    if (cc_tvalid_i && cc_tready_o) begin
      cpl_o[beat*64 +: 64] <= cc_tdata_i;
      beat <= cc_tlast_i ? 0 : beat + 1;
      if (cc_tlast_i) cpl_cnt_o <= cpl_cnt_o + 1;
    end
  end
endmodule : pcpio_core_model

// *** testbench/pcpio_target_asserts.sv ***
// assertions on the completer ports
`timescale 1ns/100ps
module pcpio_target_asserts
  import pcpio_pkg::*;
#(
  parameter int DATA_WIDTH = PCPIO_DEF_WIDTH
)(
  input wire logic                     core_clk_i,
  input wire logic                     resetn_i,
  input wire logic [DATA_WIDTH-1:0]    cq_tdata_i,
  input wire logic                     cq_tvalid_i,
  input wire logic                     cq_tlast_i,
  input wire logic                     completer_request_ready_o,
  input wire logic [DATA_WIDTH-1:0]    cc_tdata_o,
  input wire logic [DATA_WIDTH/32-1:0] cc_tkeep_o,
  input wire logic                     cc_tvalid_o,
  input wire logic                     cc_tlast_o,
  input wire logic                     cc_tready_i,
  input wire logic                     write_busy_o,
  input wire logic                     cpl_sent_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================
  // first completion beat tracker
  logic first;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) first <= 1'b1;
    else if (cc_tvalid_o && cc_tready_i) first <= cc_tlast_o;
  end
  // ==========================================================
  // properties
  busy_blocks_ready_a: assert property (write_busy_o |->
    !completer_request_ready_o) else $error("ready high during write");
  ready_drop_a: assert property (completer_request_ready_o &&
    cq_tvalid_i && cq_tlast_i |=> !completer_request_ready_o)
    else $error("ready stayed high after last beat");
  write_ready_back_a: assert property (write_busy_o |=>
    !write_busy_o && (completer_request_ready_o ^ cc_tvalid_o))
    else $error("ready not back after write");
  keep_valid_a: assert property (cc_tkeep_o[0] == cc_tvalid_o)
    else $error("keep does not follow valid");
  cpl_blocks_ready_a: assert property (cc_tvalid_o |->
    !completer_request_ready_o) else $error("ready high during read");
  cpl_hold_a: assert property (cc_tvalid_o && !cc_tready_i |=>
    cc_tvalid_o && $stable(cc_tdata_o)) else $error("completion dropped");
  sent_pulse_a: assert property (cc_tvalid_o && cc_tready_i &&
    cc_tlast_o |=> cpl_sent_o && completer_request_ready_o ##1 !cpl_sent_o)
    else $error("sent pulse or ready wrong");
  sent_cause_a: assert property (cpl_sent_o |->
    $past(cc_tvalid_o && cc_tready_i && cc_tlast_o))
    else $error("sent pulse without completion");
  cpl_status_a: assert property (cc_tvalid_o && first |->
    cc_tdata_o[45:43] == PCPIO_CPL_SUCCESS &&
    cc_tdata_o[28:16] == PCPIO_CPL_BYTES) else $error("bad status field");
  cpl_dwords_a: assert property (cc_tvalid_o && first |->
    cc_tdata_o[42:32] <= 11'h001) else $error("too many dwords");
  wr_cov: cover property (write_busy_o);
  cpl_cov: cover property (cpl_sent_o);
  stall_cov: cover property (cc_tvalid_o && !cc_tready_i);
endmodule : pcpio_target_asserts

// *** testbench/testbench.sv ***
// self-checking bench for the programmed-io completer
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
  import pcpio_pkg::*;
  typedef struct packed {
    logic [3:0]  typ;
    logic [2:0]  bar;
    logic [11:0] adr;
    logic [31:0] dat;
    logic        cpl;
  } pcpio_row_t;
  logic         core_clk_i = 1'b0;
  logic         resetn_i   = 1'b0;
  logic         stall      = 1'b0;
  logic [63:0]  cq_tdata, cc_tdata;
  logic         cq_tvalid, cq_tlast, ready, cc_tvalid, cc_tlast, cc_tready;
  logic [1:0]   cc_tkeep;
  logic         write_busy, cpl_sent;
  logic [127:0] cpl;
  int           cpl_cnt, n0, mismatches = 0, checks_done = 0, cycles = 0;
  logic         ro_valid, ro_last;
  int           ro_cpls = 0, n1;
  pcpio_row_t   rows [12] = '{
    '{PCPIO_REQ_MWR,  PCPIO_BAR_MEM64, 12'h010, 32'hA1A1A1A1, 1'b0},
    '{PCPIO_REQ_MWR,  PCPIO_BAR_MEM32, 12'h010, 32'hB2B2B2B2, 1'b0},
    '{PCPIO_REQ_MWR,  PCPIO_BAR_EROM,  12'h010, 32'hC6C6C6C6, 1'b0},
    '{PCPIO_REQ_IOWR, PCPIO_BAR_IO,    12'h010, 32'hD0D0D0D0, 1'b1},
    '{PCPIO_REQ_MRD,  PCPIO_BAR_MEM64, 12'h010, 32'hA1A1A1A1, 1'b1},
    '{PCPIO_REQ_MRD,  PCPIO_BAR_MEM32, 12'h010, 32'hB2B2B2B2, 1'b1},
    '{PCPIO_REQ_MRD,  PCPIO_BAR_EROM,  12'h010, 32'hC6C6C6C6, 1'b1},
    '{PCPIO_REQ_IORD, PCPIO_BAR_IO,    12'h010, 32'hD0D0D0D0, 1'b1},
    '{PCPIO_REQ_MRD,  PCPIO_BAR_MEM64, 12'h810, 32'hA1A1A1A1, 1'b1},
    '{PCPIO_REQ_MWR,  3'h3,            12'h010, 32'hE3E3E3E3, 1'b0},
    '{PCPIO_REQ_MRD,  3'h7,            12'h010, 32'h00000000, 1'b0},
    '{PCPIO_REQ_MWR,  PCPIO_BAR_MEM64, 12'h010, 32'hFFFFFFFF, 1'b0}
  };
  always #12.5 core_clk_i = ~core_clk_i;
  pcpio_target #(.DATA_WIDTH(64), .IO_ENABLE(1'b1)) pcpio_target_i (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .cq_tdata_i(cq_tdata),
    .cq_tvalid_i(cq_tvalid), .cq_tlast_i(cq_tlast),
    .completer_request_ready_o(ready), .cc_tdata_o(cc_tdata),
    .cc_tkeep_o(cc_tkeep), .cc_tvalid_o(cc_tvalid), .cc_tlast_o(cc_tlast),
    .cc_tready_i(cc_tready), .write_busy_o(write_busy),
    .cpl_sent_o(cpl_sent));
  pcpio_core_model pcpio_core_model_i (
    .core_clk_i(core_clk_i), .stall_i(stall), .ready_i(ready),
    .cq_tdata_o(cq_tdata), .cq_tvalid_o(cq_tvalid), .cq_tlast_o(cq_tlast),
    .cc_tdata_i(cc_tdata), .cc_tvalid_i(cc_tvalid), .cc_tlast_i(cc_tlast),
    .cc_tready_o(cc_tready), .cpl_o(cpl), .cpl_cnt_o(cpl_cnt));
  // second completer with the io region left off
  if (1) begin : g_io_off
    pcpio_target #(.DATA_WIDTH(64)) pcpio_target_i (
      .core_clk_i(core_clk_i), .resetn_i(resetn_i), .cq_tdata_i(cq_tdata),
      .cq_tvalid_i(cq_tvalid && ready), .cq_tlast_i(cq_tlast),
      .completer_request_ready_o(), .cc_tdata_o(), .cc_tkeep_o(),
      .cc_tvalid_o(ro_valid), .cc_tlast_o(ro_last),
      .cc_tready_i(cc_tready), .write_busy_o(), .cpl_sent_o());
  end
  always @(posedge core_clk_i) begin
    if (ro_valid && cc_tready && ro_last) ro_cpls <= ro_cpls + 1;
  end
  // ==========================================================
  // helpers
  function automatic logic [191:0] req(pcpio_row_t w, logic [10:0] n,
                                       logic [7:0] tg);
    logic [191:0] r;
    r = '0;
    r[PCPIO_ADDR_LO +: 10]    = w.adr[11:2];
    r[PCPIO_DWCNT_LO +: 11]   = n;
    r[PCPIO_TYPE_LO +: 4]     = w.typ;
    r[PCPIO_REQID_LO +: 16]   = 16'hA5C3;
    r[PCPIO_TAG_LO +: 8]      = tg;
    r[PCPIO_BAR_LO +: 3]      = w.bar;
    r[PCPIO_ATTR_LO +: 3]     = 3'h5;
    r[PCPIO_PAYLOAD_LO +: 32] = w.dat;
    return r;
  endfunction : req
  task automatic send(pcpio_row_t w, logic [10:0] n, logic [7:0] tg);
    pcpio_core_model_i.send(req(w, n, tg), (w.typ == PCPIO_REQ_MWR ||
      w.typ == PCPIO_REQ_IOWR) ? 3 : 2);
  endtask : send
  task automatic run(pcpio_row_t w, logic [10:0] n, logic [7:0] tg);
    int k;
    logic [10:0] edw;
    n0 = cpl_cnt;
    n1 = ro_cpls;
    edw = 11'(w.typ != PCPIO_REQ_IOWR);
    send(w, n, tg);
    @(posedge core_clk_i);
    for (k = 0; k < 40 && ready !== 1'b1; k++) @(posedge core_clk_i);
    `CHK("cpl count", n0 + w.cpl, cpl_cnt)
    `CHK("io off", n1 + (w.cpl && w.bar != PCPIO_BAR_IO), ro_cpls)
    if (w.cpl) begin
      `CHK("cpl tag", tg, cpl[PCPIO_C_TAG_LO +: 8])
      `CHK("cpl reqid", 16'hA5C3, cpl[PCPIO_C_REQID_LO +: 16])
      `CHK("cpl attr", 3'h5, cpl[PCPIO_C_ATTR_LO +: 3])
      `CHK("cpl dwords", edw, cpl[PCPIO_C_DWCNT_LO +: 11])
      if (w.typ != PCPIO_REQ_IOWR)
        `CHK("cpl data", w.dat, cpl[PCPIO_C_DATA_LO +: 32])
    end
  endtask : run
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  // ==========================================================
  // tests
  initial begin
    repeat (11) @(posedge core_clk_i);
    `CHK("ready in reset", 1'b1, ready)
    `CHK("cc valid in reset", 1'b0, cc_tvalid)
    @(posedge core_clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 11; i++) run(rows[i], 11'h001, 8'(i));
    $display("table test done");
    run(rows[11], 11'h002, 8'h40);
    run(rows[4], 11'h001, 8'h41);
    run(rows[7], 11'h001, 8'h42);
    $display("oversize drop test done");
    stall <= 1'b1;
    n0 = cpl_cnt;
    send('{PCPIO_REQ_MWR, PCPIO_BAR_MEM32, 12'h7FC, 32'h12345678, 1'b0},
         11'h001, 8'h50);
    send(rows[6], 11'h001, 8'h51);
    send('{PCPIO_REQ_MRD, PCPIO_BAR_MEM32, 12'h7FC, 32'h0, 1'b1},
         11'h001, 8'h52);
    for (int k = 0; k < 80 && cpl_cnt != n0 + 2; k++) @(posedge core_clk_i);
    `CHK("b2b count", n0 + 2, cpl_cnt)
    `CHK("b2b data", 32'h12345678, cpl[PCPIO_C_DATA_LO +: 32])
    stall <= 1'b0;
    $display("back to back test done");
    resetn_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    `CHK("ready mid reset", 1'b1, ready)
    resetn_i <= 1'b1;
    run(rows[5], 11'h001, 8'h60);
    $display("second reset test done");
    test_done();
  end
endmodule : testbench
bind pcpio_target pcpio_target_asserts #(.DATA_WIDTH(DATA_WIDTH)) chk_i (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .cq_tdata_i(cq_tdata_i),
  .cq_tvalid_i(cq_tvalid_i), .cq_tlast_i(cq_tlast_i),
  .completer_request_ready_o(completer_request_ready_o),
  .cc_tdata_o(cc_tdata_o), .cc_tkeep_o(cc_tkeep_o),
  .cc_tvalid_o(cc_tvalid_o), .cc_tlast_o(cc_tlast_o),
  .cc_tready_i(cc_tready_i), .write_busy_o(write_busy_o),
  .cpl_sent_o(cpl_sent_o));
